// *** shu_pkg.sv ***
// Purpose: shared constants for the serial host port uart
// Assumes: 32-bit axi4-lite register bus, one clock
// Notes:   offsets are byte addresses, one aligned word per register
package shu_pkg;
	// register byte offsets
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] TXDATA_OFS = 4'h8;
	localparam logic [3:0] RXDATA_OFS = 4'hc;
	// control field positions and reset values
	localparam int         BAUD_LSB   = 0;
	localparam int         FMT_LSB    = 4;
	localparam logic [2:0] BAUD_RST   = 3'h5; // 9600 baud
	localparam logic [1:0] FMT_RST    = 2'h0; // no parity, 8 data bits
	// character formats
	localparam logic [1:0] FMT_NONE8  = 2'h0;
	localparam logic [1:0] FMT_EVEN7  = 2'h1;
	localparam logic [1:0] FMT_ODD7   = 2'h2;
	// status bit positions
	localparam int         ST_TXEMPTY = 0;
	localparam int         ST_TXFULL  = 1;
	localparam int         ST_RXAVAIL = 2;
	localparam int         ST_PARERR  = 3;
	localparam int         ST_FRMERR  = 4;
	localparam int         ST_OVERRUN = 5;
	localparam int         ST_DSR     = 6;
	localparam int         ST_DTR     = 7;
	// frame geometry: start + 8 payload slots + 2 stop = 11 either way
	localparam int         FRAME_BITS = 11;
	localparam int         RX_BITS    = 10;   // slots after the start bit
	// timing
	localparam int         CLK_HZ     = 100_000_000;
	localparam int         CNT_W      = 24;
	localparam int         FIFO_DEPTH = 8;
	localparam int         FIFO_WIDTH = 8;
	// selectable bit rates, index is the control field value
	localparam int         BAUD_300   = 300;
	localparam int         BAUD_600   = 600;
	localparam int         BAUD_1200  = 1200;
	localparam int         BAUD_2400  = 2400;
	localparam int         BAUD_4800  = 4800;
	localparam int         BAUD_9600  = 9600;
	// axi responses
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLV   = 2'h2;
endpackage

// *** shu_fifo.sv ***
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   in_ready does not look at in_valid, so callers may gate on it
`timescale 1ns/1ps
module shu_fifo #(
	parameter int WIDTH = shu_pkg::FIFO_WIDTH,
	parameter int DEPTH = shu_pkg::FIFO_DEPTH
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];  // storage words
	logic [AW-1:0]    wr_q;           // write pointer
	logic [AW-1:0]    rd_q;           // read pointer
	logic [AW:0]      cnt_q;          // occupancy
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH)); // honest full
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage write, no reset needed on data
	always_ff @(posedge aclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers and count; wrap explicitly since depth may not be a power of two
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + (AW+1)'(1);
			end else if (pop && !push) begin
				cnt_q <= cnt_q - (AW+1)'(1);
			end
		end
	end
endmodule

// *** shu_uart.sv ***
// Purpose: serial host port uart with axi4-lite register access
// Assumes: 100 MHz aclk, synchronous active-low aresetn, terminal-equipment pinout
// Notes:   transmit path is buffered by an 8-word fifo; receive holds one character
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
// Summary of operation
// - six bit rates, 9600 after reset
// - formats: none/8, even/7, odd/7; none default
// - exactly one start bit, fixed
// - exactly two stop bits, fixed
// - parity frame: start, 7 data, parity, stops
// - plain frame: start, 8 data, two stops
// - drive dtr, sense dsr for pacing
// - terminal pin roles: txd out, rxd in
module shu_uart #(
	parameter int CLK_HZ = shu_pkg::CLK_HZ
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             txd,
	input  wire logic        rxd,
	output logic             dtr,
	input  wire logic        dsr
);
	localparam int CW = shu_pkg::CNT_W;

	typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} shu_tx_type;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} shu_rx_type;

	// cycles per bit for a rate selection; unused codes fall back to 9600
	function automatic logic [CW-1:0] bit_cycles(input logic [2:0] sel);
		int rate;
		case (sel)
			3'h0:    rate = shu_pkg::BAUD_300;
			3'h1:    rate = shu_pkg::BAUD_600;
			3'h2:    rate = shu_pkg::BAUD_1200;
			3'h3:    rate = shu_pkg::BAUD_2400;
			3'h4:    rate = shu_pkg::BAUD_4800;
			default: rate = shu_pkg::BAUD_9600;
		endcase
		return CW'(CLK_HZ / rate);
	endfunction

	// parity bit over seven data bits only
	function automatic logic par_bit(input logic [6:0] d, input logic odd);
		return odd ? ~^d : ^d;
	endfunction

	// pin synchronisers: first stage feeds only the second
	logic        rxd_m_q;            // rxd first stage
	logic        rxd_s_q;            // rxd synchronised
	logic        dsr_m_q;            // dsr first stage
	logic        dsr_s_q;            // dsr synchronised

	// control register
	logic [2:0]  baud_q;             // rate selection
	logic [1:0]  fmt_q;              // character format

	// axi write side
	logic        aw_held_q;          // write address captured
	logic        w_held_q;           // write data captured
	logic [3:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        wr_fire;            // both halves present and target can take it
	// axi read side
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        rd_fire;
	logic        rx_pop;             // read of the receive data register

	// transmit fifo and serialiser
	logic        fifo_in_valid;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic        fifo_out_ready;
	logic [7:0]  fifo_out_data;
	shu_tx_type  tx_state_q;
	logic [CW-1:0] tx_cnt_q;          // cycles left in current bit
	logic [3:0]  tx_idx_q;           // bit slot being sent
	logic [shu_pkg::FRAME_BITS-1:0] tx_sh_q;  // frame, lsb goes out first
	logic        txd_q;

	// receiver
	shu_rx_type  rx_state_q;
	logic [CW-1:0] rx_cnt_q;
	logic [3:0]  rx_idx_q;
	logic [shu_pkg::RX_BITS-1:0] rx_sh_q;    // slots after the start bit
	logic        rx_done;            // last stop slot sampled this cycle
	logic [7:0]  rx_data_q;          // holding register
	logic        rx_avail_q;         // holding register full
	logic        par_err_q;          // sticky parity error
	logic        frm_err_q;          // sticky framing error
	logic        ovr_err_q;          // sticky overrun
	logic [7:0]  status;             // assembled status word
	logic        st_clr;             // write-one-to-clear strobe on status
	logic [shu_pkg::RX_BITS-1:0] rx_word;    // completed slots incl. last sample

	// two-flop synchronisers for the incoming pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxd_m_q <= 1'b1;
			rxd_s_q <= 1'b1;
			dsr_m_q <= 1'b0;
			dsr_s_q <= 1'b0;
		end else begin
			rxd_m_q <= rxd;
			rxd_s_q <= rxd_m_q;
			dsr_m_q <= dsr;
			dsr_s_q <= dsr_m_q;
		end
	end

	// ----- axi4-lite write channel -----
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	// a data write stalls here while the fifo is full: back-pressure to software
	assign wr_fire = aw_held_q && w_held_q && !bvalid_q &&
		(awaddr_q != shu_pkg::TXDATA_OFS || fifo_in_ready);
	assign fifo_in_valid = wr_fire && awaddr_q == shu_pkg::TXDATA_OFS && wstrb_q[0];
	assign st_clr = wr_fire && awaddr_q == shu_pkg::STATUS_OFS && wstrb_q[0];

	// capture address and data in either order, then answer once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 4'h0;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= shu_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= {s_axi_awaddr[3:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				// the receive data register is read-only
				if (awaddr_q == shu_pkg::RXDATA_OFS) begin
					bresp_q <= shu_pkg::RESP_SLV;
				end else begin
					bresp_q <= shu_pkg::RESP_OKAY;
				end
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// control register: rate and format selection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			baud_q <= shu_pkg::BAUD_RST;
			fmt_q  <= shu_pkg::FMT_RST;
		end else if (wr_fire && awaddr_q == shu_pkg::CTRL_OFS && wstrb_q[0]) begin
			baud_q <= wdata_q[shu_pkg::BAUD_LSB +: 3];
			fmt_q  <= wdata_q[shu_pkg::FMT_LSB +: 2];
		end
	end

	// ----- axi4-lite read channel -----
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign rx_pop        = rd_fire && s_axi_araddr[3:2] == shu_pkg::RXDATA_OFS[3:2];

	always_comb begin
		status = 8'h0;
		status[shu_pkg::ST_TXEMPTY] = !fifo_out_valid && tx_state_q == TX_IDLE;
		status[shu_pkg::ST_TXFULL]  = !fifo_in_ready;
		status[shu_pkg::ST_RXAVAIL] = rx_avail_q;
		status[shu_pkg::ST_PARERR]  = par_err_q;
		status[shu_pkg::ST_FRMERR]  = frm_err_q;
		status[shu_pkg::ST_OVERRUN] = ovr_err_q;
		status[shu_pkg::ST_DSR]     = dsr_s_q;
		status[shu_pkg::ST_DTR]     = dtr;
	end

	// read mux; unmapped never happens in a 4-word space, tx data reads zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= shu_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rresp_q  <= shu_pkg::RESP_OKAY;
			if (s_axi_araddr[3:2] == shu_pkg::CTRL_OFS[3:2]) begin
				rdata_q <= {26'h0, fmt_q, 1'b0, baud_q};
			end else if (s_axi_araddr[3:2] == shu_pkg::STATUS_OFS[3:2]) begin
				rdata_q <= {24'h0, status};
			end else if (s_axi_araddr[3:2] == shu_pkg::RXDATA_OFS[3:2]) begin
				rdata_q <= {24'h0, rx_data_q};
			end else begin
				rdata_q <= 32'h0;
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ----- transmit path -----
	shu_fifo #(
		.WIDTH (shu_pkg::FIFO_WIDTH),
		.DEPTH (shu_pkg::FIFO_DEPTH)
	) u_txfifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (wdata_q[7:0]),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// a new frame starts only while the host reports ready
	assign fifo_out_ready = tx_state_q == TX_IDLE && dsr_s_q;
	assign txd = txd_q;

	// serialiser: one 11-slot frame, whatever the format
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state_q <= TX_IDLE;
			tx_cnt_q   <= '0;
			tx_idx_q   <= 4'h0;
			tx_sh_q    <= '1;
			txd_q      <= 1'b1;
		end else begin
			case (tx_state_q)
				TX_IDLE: begin
					txd_q <= 1'b1;
					if (fifo_out_valid && fifo_out_ready) begin
						// two stops, slot 8, seven data bits, one start
						tx_sh_q <= {2'b11,
							(fmt_q == shu_pkg::FMT_EVEN7 || fmt_q == shu_pkg::FMT_ODD7)
								? par_bit(fifo_out_data[6:0], fmt_q == shu_pkg::FMT_ODD7)
								: fifo_out_data[7],
							fifo_out_data[6:0], 1'b0};
						tx_cnt_q   <= bit_cycles(baud_q);
						tx_idx_q   <= 4'h0;
						tx_state_q <= TX_SHIFT;
						txd_q      <= 1'b0;
					end
				end
				TX_SHIFT: begin
					txd_q <= tx_sh_q[0];
					if (tx_cnt_q == CW'(1)) begin
						tx_cnt_q <= bit_cycles(baud_q);
						tx_sh_q  <= {1'b1, tx_sh_q[shu_pkg::FRAME_BITS-1:1]};
						tx_idx_q <= tx_idx_q + 4'h1;
						txd_q    <= tx_sh_q[1];
						if (tx_idx_q == 4'(shu_pkg::FRAME_BITS - 1)) begin
							tx_state_q <= TX_IDLE;
							txd_q      <= 1'b1;
						end
					end else begin
						tx_cnt_q <= tx_cnt_q - CW'(1);
					end
				end
				default: tx_state_q <= TX_IDLE;
			endcase
		end
	end

	// ----- receive path -----
	assign rx_done = rx_state_q == RX_BITS && rx_cnt_q == CW'(1) &&
		rx_idx_q == 4'(shu_pkg::RX_BITS - 1);
	assign rx_word = {rxd_s_q, rx_sh_q[shu_pkg::RX_BITS-2:0]};
	// ready to the host only while the holding register is empty
	assign dtr = !rx_avail_q;

	// deserialiser: half a bit to the middle of start, then whole bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_q <= RX_IDLE;
			rx_cnt_q   <= '0;
			rx_idx_q   <= 4'h0;
			rx_sh_q    <= '0;
		end else begin
			case (rx_state_q)
				RX_IDLE: begin
					if (!rxd_s_q) begin
						rx_cnt_q   <= bit_cycles(baud_q) >> 1;
						rx_state_q <= RX_START;
					end
				end
				RX_START: begin
					if (rx_cnt_q <= CW'(1)) begin
						// a glitch shorter than half a bit is dropped
						rx_state_q <= rxd_s_q ? RX_IDLE : RX_BITS;
						rx_cnt_q   <= bit_cycles(baud_q);
						rx_idx_q   <= 4'h0;
					end else begin
						rx_cnt_q <= rx_cnt_q - CW'(1);
					end
				end
				RX_BITS: begin
					if (rx_cnt_q == CW'(1)) begin
						rx_sh_q[rx_idx_q] <= rxd_s_q;
						rx_cnt_q <= bit_cycles(baud_q);
						rx_idx_q <= rx_idx_q + 4'h1;
						if (rx_done) begin
							rx_state_q <= RX_IDLE;
						end
					end else begin
						rx_cnt_q <= rx_cnt_q - CW'(1);
					end
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// holding register and sticky errors; a new event wins over a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_data_q  <= 8'h0;
			rx_avail_q <= 1'b0;
			par_err_q  <= 1'b0;
			frm_err_q  <= 1'b0;
			ovr_err_q  <= 1'b0;
		end else begin
			if (rx_pop) begin
				rx_avail_q <= 1'b0;
			end
			if (st_clr) begin
				if (wdata_q[shu_pkg::ST_PARERR])  par_err_q <= 1'b0;
				if (wdata_q[shu_pkg::ST_FRMERR])  frm_err_q <= 1'b0;
				if (wdata_q[shu_pkg::ST_OVERRUN]) ovr_err_q <= 1'b0;
			end
			if (rx_done) begin
				rx_avail_q <= 1'b1;
				if (fmt_q == shu_pkg::FMT_EVEN7 || fmt_q == shu_pkg::FMT_ODD7) begin
					rx_data_q <= {1'b0, rx_word[6:0]};
					if (rx_word[7] != par_bit(rx_word[6:0], fmt_q == shu_pkg::FMT_ODD7)) begin
						par_err_q <= 1'b1;
					end
				end else begin
					rx_data_q <= rx_word[7:0];
				end
				if (!(rx_word[8] && rx_word[9])) begin
					frm_err_q <= 1'b1;
				end
				if (rx_avail_q && !rx_pop) begin
					ovr_err_q <= 1'b1;
				end
			end
		end
	end
endmodule

// *** shu_uart_chk.sv ***
// Purpose: port assertions for the serial host port uart
// Assumes: one clock, synchronous active-low reset
// Notes:   start bit check assumes at least 8 clocks a bit
`timescale 1ns/1ps
module shu_uart_chk #(
	parameter int CLK_HZ = shu_pkg::CLK_HZ
) (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic [3:0] s_axi_araddr,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic       s_axi_rvalid,
	input wire logic       txd,
	input wire logic       dtr
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [3:0] aw_q; // address of the write in flight
	// kept so the response can be tied to its target
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_q <= s_axi_awaddr;
		end
	end
	// a start bit holds the line low for at least 8 clocks
	sequence start_s;
		(!txd) [*8];
	endsequence
	sequence answer_s;
		##[1:2] s_axi_bvalid;
	endsequence
	rst_vals_a: assert property (disable iff (1'b0)
		!aresetn |=> txd && dtr && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not at rest after reset");
	start_bit_a: assert property ($fell(txd) |-> start_s)
		else $error("start bit too short");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && s_axi_awaddr != shu_pkg::TXDATA_OFS |-> answer_s)
		else $error("write response late");
	write_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp == ((aw_q ==
		shu_pkg::RXDATA_OFS) ? shu_pkg::RESP_SLV : shu_pkg::RESP_OKAY))
		else $error("wrong write response code");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	read_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && s_axi_rresp == shu_pkg::RESP_OKAY)
		else $error("read answer missing");
	dtr_read_a: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == shu_pkg::RXDATA_OFS |-> ##[1:3] dtr)
		else $error("ready not raised after character read");
endmodule
bind shu_uart shu_uart_chk #(.CLK_HZ(CLK_HZ)) i_shu_uart_chk (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .txd(txd), .dtr(dtr));

// *** shu_host_model.sv ***
// Purpose: host terminal at the far end of the crossover cable
// Assumes: bit time given in clocks by the caller
// Notes:   samples at falling clock edges to stay clear of txd updates
`timescale 1ns/1ps
module shu_host_model (
	input wire logic aclk,
	input wire logic txd,
	output logic     rxd
);
	initial rxd = 1'b1; // line idles at mark
	// send eleven slots, slot 0 first, then back to mark
	task automatic send_frame(input logic [10:0] bits, input int bc);
		@(posedge aclk);
		for (int i = 0; i < 11; i++) begin // one start, two stops
			rxd <= bits[i];
			repeat (bc) @(posedge aclk);
		end
		rxd <= 1'b1;
	endtask
	// wait for a start edge, then sample each slot in its middle
	task automatic recv_frame(output logic [10:0] bits, input int bc, output bit ok);
		int n;
		n = 0;
		while (txd !== 1'b0 && n < 40000) begin
			@(negedge aclk);
			n++;
		end
		ok = (n < 40000);
		repeat (bc / 2) @(negedge aclk);
		for (int i = 0; i < 11; i++) begin // lsb first
			bits[i] = txd;
			if (i < 10) repeat (bc) @(negedge aclk);
		end
	endtask
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench for the serial host port uart
// Assumes: reduced clock parameter so a 9600 bit is 10 clocks
// Notes:   random characters from a fixed seed
`timescale 1ns/1ps
module testbench;
	localparam int CLK_HZ = 96000; // short bit times
	logic        aclk, aresetn, txd, rxd, dtr, dsr;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          failures, n_compared;
	int          rates [6] = '{shu_pkg::BAUD_300, shu_pkg::BAUD_600, shu_pkg::BAUD_1200,
		shu_pkg::BAUD_2400, shu_pkg::BAUD_4800, shu_pkg::BAUD_9600};
	shu_uart #(.CLK_HZ(CLK_HZ)) i_shu_uart (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txd(txd), .rxd(rxd),
		.dtr(dtr), .dsr(dsr));
	shu_host_model i_shu_host_model (.aclk(aclk), .txd(txd), .rxd(rxd));
	// expected line slots for a character
	function automatic logic [10:0] frame(input logic [7:0] d, input logic [1:0] f);
		logic p;
		p = (f == shu_pkg::FMT_ODD7) ? ~^d[6:0] : ^d[6:0];
		return {2'b11, (f == shu_pkg::FMT_NONE8) ? d[7] : p, d[6:0], 1'b0};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one write; ready is judged before the edge, release after it
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok, w_ok, b_ok;
		int   n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			aw_ok = s_axi_awvalid && s_axi_awready;
			w_ok = s_axi_wvalid && s_axi_wready;
			b_ok = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
			n++;
		end while (!b_ok);
		s_axi_bready <= 1'b0;
		check(b_ok, 1'b1);
	endtask
	task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
		logic ar_ok, r_ok;
		int   n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(negedge aclk);
			ar_ok = s_axi_arvalid && s_axi_arready;
			r_ok = s_axi_rvalid;
			d = s_axi_rdata;
			@(posedge aclk);
			if (ar_ok) s_axi_arvalid <= 1'b0;
			n++;
		end while (!r_ok);
		s_axi_rready <= 1'b0;
		check(r_ok, 1'b1);
	endtask
	// host sends a frame, bench checks what the status shows
	task automatic rx_status(input logic [10:0] fr, input logic [31:0] exp);
		logic [31:0] w;
		i_shu_host_model.send_frame(fr, 10);
		axi_read(shu_pkg::STATUS_OFS, w);
		check(w & 32'h38, exp);
	endtask
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// watchdog: the run needs under 20k clocks, allow about twice that
	initial begin
		#400_000;
		failures++;
		$display("ERROR %0t: watchdog expired", $time);
		results();
	end
	initial begin
		logic [31:0] v, w;
		logic [10:0] fr;
		logic [7:0]  c [$];
		logic [1:0]  rs, f;
		bit          ok;
		{aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		dsr = 1'b1;
		void'($urandom(25449));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(shu_pkg::CTRL_OFS, v);
		check(v, 32'h05);
		axi_read(shu_pkg::STATUS_OFS, v);
		check(v, 32'hc1);
		check(txd, 1'b1);
		$display("test reset done");
		for (int b = 0; b < 6; b++) begin
			f = 2'(b % 3);
			axi_write(shu_pkg::CTRL_OFS, 32'(b) | (32'(f) << 4), rs);
			axi_read(shu_pkg::CTRL_OFS, w);
			check(w, 32'(b) | (32'(f) << 4));
			v = $urandom;
			fork
				i_shu_host_model.recv_frame(fr, CLK_HZ / rates[b], ok);
				axi_write(shu_pkg::TXDATA_OFS, v, rs);
			join
			check({ok, fr}, {1'b1, frame(v[7:0], f)});
			v = $urandom;
			i_shu_host_model.send_frame(frame(v[7:0], f), CLK_HZ / rates[b]);
			repeat (4) @(negedge aclk);
			check(dtr, 1'b0);
			axi_read(shu_pkg::RXDATA_OFS, w);
			check(w, (f == shu_pkg::FMT_NONE8) ? v[7:0] : v[6:0]);
			$display("test rate %0d done", rates[b]);
		end
		v = $urandom;
		rx_status(frame(v[7:0], f) ^ 11'h100, 32'h08);
		axi_read(shu_pkg::RXDATA_OFS, w);
		axi_write(shu_pkg::STATUS_OFS, 32'h38, rs);
		rx_status(frame(v[7:0], f) ^ 11'h400, 32'h10);
		axi_write(shu_pkg::STATUS_OFS, 32'h38, rs);
		rx_status(frame(v[7:0], f), 32'h20);
		axi_read(shu_pkg::RXDATA_OFS, w);
		axi_write(shu_pkg::RXDATA_OFS, 32'h5a, rs);
		check(rs, shu_pkg::RESP_SLV);
		$display("test line faults done");
		dsr <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			c.push_back(8'($urandom));
			axi_write(shu_pkg::TXDATA_OFS, {24'h0, c[i]}, rs);
		end
		axi_read(shu_pkg::STATUS_OFS, w);
		check(w & 32'h43, 32'h02);
		check(txd, 1'b1);
		fork
			for (int i = 0; i < 8; i++) begin
				i_shu_host_model.recv_frame(fr, 10, ok);
				check({ok, fr}, {1'b1, frame(c[i], f)});
			end
			dsr <= 1'b1;
		join
		repeat (12) @(posedge aclk);
		axi_read(shu_pkg::STATUS_OFS, w);
		check(w & 32'h03, 32'h01);
		$display("test fifo done");
		// spare codes: rate 7 and format 3 are stored and read back as written
		axi_write(shu_pkg::CTRL_OFS, 32'h37, rs);
		axi_read(shu_pkg::CTRL_OFS, w);
		check(w, 32'h37);
		check(rs, shu_pkg::RESP_OKAY);
		$display("test spare codes done");
		results();
	end
endmodule
